// [include/trs_pkg.sv]
// Constants shared by the transceiver-channel reset sequencer and its transceiver end.
// Assumes a single 125 MHz parallel clock and an active-low asynchronous reset.
// Operation
// - Rx-only auto: hold rx resets until busy drops.
// - After busy drops, wait two cycles, release analog.
// - Auto: freqlock high, wait interval, release digital.
// - Manual: hold digital, lock-to-ref; lock-to-data low.
// - Manual: analog release makes CDR PLL lock.
// - Swap lock-to-ref for lock-to-data in one cycle.
// - Lock-to-data puts CDR into data locking.
// - Manual: release digital after data-lock interval.
// - Transmitter: hold PLL reset at least 1 us.
// - PLL reset holds all others; then PLL locks.
// - PLL lock releases transmit digital reset.
// - Busy pulses at power-up and on reconfiguration.
// - Lost reference clock drops PLL lock.
// - On relock, rerun sequence from PLL-locked step.
// - Each non-bonded channel sequenced independently.
package trs_pkg;
   // Parallel clock period in picoseconds.
   localparam int unsigned CLK_PERIOD_PS       = 8000;
   // Least PLL reset time in nanoseconds, rounded up to cycles.
   localparam int unsigned PLL_RESET_NS        = 1000;
   localparam int unsigned PLL_RESET_CYC       = (PLL_RESET_NS * 1000 + CLK_PERIOD_PS - 1)
                                                 / CLK_PERIOD_PS;
   // Cycles between busy falling and analog release.
   localparam int unsigned BUSY_GAP_CYC        = 2;
   // Default wait intervals in cycles; set them per channel at instantiation.
   localparam int unsigned AUTO_LOCK_CYC       = 32;
   localparam int unsigned REF_TO_DATA_CYC     = 32;
   localparam int unsigned MANUAL_LOCK_CYC     = 32;
   // Transceiver model: power-up offset cancellation busy length and lock delays.
   localparam int unsigned CAL_BUSY_CYC        = 16;
   localparam int unsigned PLL_LOCK_CYC        = 20;
   localparam int unsigned CDR_LOCK_CYC        = 12;
   localparam int unsigned CNT_W               = 16;
   // Sequencer states, one-hot.
   typedef enum logic [8:0] {
      TRS_PLL_RST   = 9'h001,
      TRS_PLL_WAIT  = 9'h002,
      TRS_BUSY_WAIT = 9'h004,
      TRS_GAP       = 9'h008,
      TRS_FREQ_WAIT = 9'h010,
      TRS_AUTO_WAIT = 9'h020,
      TRS_REF_WAIT  = 9'h040,
      TRS_DATA_WAIT = 9'h080,
      TRS_READY     = 9'h100
   } trs_state_e;
endpackage : trs_pkg

// [include/trs_link_if.sv]
// Signals between the reset sequencer (core end) and the transceiver channel.
// Assumes both ends share the parallel clock.
`timescale 1ns/1ps
interface trs_link_if;
   logic pll_reset;        // Transmit PLL reset, high active.
   logic tx_digital_reset; // Transmit PCS reset, high active.
   logic rx_analog_reset;  // Receive PMA reset, high active.
   logic rx_digital_reset; // Receive PCS reset, high active.
   logic lock_to_ref;      // CDR lock-to-reference control.
   logic lock_to_data;     // CDR lock-to-data control.
   logic pll_locked;       // Transmit PLL locked.
   logic rx_freq_locked;   // CDR frequency locked (automatic mode).
   logic rx_pll_locked;    // CDR PLL locked (manual mode).
   logic busy;             // Reconfiguration busy.
   modport ctrl (output pll_reset, tx_digital_reset, rx_analog_reset, rx_digital_reset,
                 lock_to_ref, lock_to_data,
                 input  pll_locked, rx_freq_locked, rx_pll_locked, busy);
   modport xcvr (input  pll_reset, tx_digital_reset, rx_analog_reset, rx_digital_reset,
                 lock_to_ref, lock_to_data,
                 output pll_locked, rx_freq_locked, rx_pll_locked, busy);
endinterface : trs_link_if

// [src/trs_xcvr.sv]
// Behavioural transceiver channel end: PLL, CDR lock and busy generation.
// Assumes the sequencer on the ctrl modport and a reference-clock-good level from outside.
`timescale 1ns/1ps
module trs_xcvr (
   input  wire logic   CORE_CLK,     // Parallel clock.
   input  wire logic   RST_N,        // Asynchronous reset, active low.
   trs_link_if.xcvr    link,         // Link to the sequencer.
   input  wire logic   REFCLK_OK,    // Reference clock present and stable (pin).
   input  wire logic   RECONFIG_REQ, // Reconfiguration read or write, one-cycle pulse.
   output logic        CDR_IN_DATA   // CDR is in lock-to-data mode.
);
   logic [2:0]              ref_sync;
   logic [trs_pkg::CNT_W-1:0] cal_cnt;
   logic [trs_pkg::CNT_W-1:0] pll_cnt;
   logic [trs_pkg::CNT_W-1:0] cdr_cnt;
   logic                    cal_done;
   logic                    reconf_busy;
   logic                    ref_good;
   logic                    ref_good_q;

   // Three-stage synchroniser; the change counts once stages two and three agree.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_sync   <= 3'h0;
         ref_good_q <= 1'b0;
      end else begin
         ref_sync <= {ref_sync[1:0], REFCLK_OK};
         if (ref_sync[1] == ref_sync[2]) begin
            ref_good_q <= ref_sync[2];
         end
      end
   end
   assign ref_good = ref_good_q;

   // Busy only during offset cancellation and for a cycle per reconfiguration access.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cal_cnt     <= '0;
         cal_done    <= 1'b0;
         reconf_busy <= 1'b0;
         link.busy   <= 1'b0;
      end else begin
         if (!cal_done) begin
            cal_cnt <= cal_cnt + 1'b1;
            if (cal_cnt == trs_pkg::CNT_W'(trs_pkg::CAL_BUSY_CYC)) begin
               cal_done <= 1'b1;
            end
         end
         reconf_busy <= RECONFIG_REQ;
         link.busy   <= (!cal_done && cal_cnt != '0) || reconf_busy;
      end
   end

   // PLL locks a while after its reset drops, and only with a good reference.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pll_cnt         <= '0;
         link.pll_locked <= 1'b0;
      end else if (link.pll_reset || !ref_good) begin
         pll_cnt         <= '0;
         link.pll_locked <= 1'b0;
      end else if (pll_cnt == trs_pkg::CNT_W'(trs_pkg::PLL_LOCK_CYC)) begin
         link.pll_locked <= 1'b1;
      end else begin
         pll_cnt <= pll_cnt + 1'b1;
      end
   end

   // CDR: analog reset release gives PLL lock; lock-to-data enters data mode.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cdr_cnt             <= '0;
         link.rx_pll_locked  <= 1'b0;
         link.rx_freq_locked <= 1'b0;
         CDR_IN_DATA         <= 1'b0;
      end else if (link.rx_analog_reset) begin
         cdr_cnt             <= '0;
         link.rx_pll_locked  <= 1'b0;
         link.rx_freq_locked <= 1'b0;
         CDR_IN_DATA         <= 1'b0;
      end else begin
         link.rx_pll_locked <= 1'b1;
         CDR_IN_DATA        <= link.lock_to_data;
         if (cdr_cnt != trs_pkg::CNT_W'(trs_pkg::CDR_LOCK_CYC)) begin
            cdr_cnt <= cdr_cnt + 1'b1;
         end else begin
            link.rx_freq_locked <= 1'b1;
         end
      end
   end
endmodule : trs_xcvr

// [src/trs_ctrl.sv]
// Core-side reset sequencer for one non-bonded transceiver channel.
// Assumes busy and lock inputs share CORE_CLK; instantiate once per channel.
`timescale 1ns/1ps
module trs_ctrl #(
   parameter int unsigned AUTO_LOCK_CYC   = trs_pkg::AUTO_LOCK_CYC,   // Auto data-lock wait.
   parameter int unsigned REF_TO_DATA_CYC = trs_pkg::REF_TO_DATA_CYC, // ref_to_data_wait.
   parameter int unsigned MANUAL_LOCK_CYC = trs_pkg::MANUAL_LOCK_CYC  // Manual data-lock wait.
) (
   input  wire logic   CORE_CLK,  // Parallel clock.
   input  wire logic   RST_N,     // Asynchronous reset, active low.
   trs_link_if.ctrl    link,      // Link to the transceiver.
   input  wire logic   HAS_TX,    // Transmitter present.
   input  wire logic   MANUAL,    // CDR manual lock mode.
   output logic        TX_READY,  // Transmitter ready for data.
   output logic        RX_READY   // Receiver ready for data.
);
   // ***************************************************************
   // Sequencer state
   // ***************************************************************
   trs_pkg::trs_state_e        state;
   trs_pkg::trs_state_e        next_state;
   logic [trs_pkg::CNT_W-1:0]  cnt;
   logic                       cnt_clr;
   logic                       busy_seen;
   logic                       pll_lost;
   logic                       wait_done;

   // Counter compare shared by every timed state.
   function automatic logic reached(input logic [trs_pkg::CNT_W-1:0] c,
                                    input int unsigned lim);
      reached = (c >= trs_pkg::CNT_W'(lim));
   endfunction : reached

   // Loss of PLL lock after it was seen sends the sequence back to the PLL-locked step.
   assign pll_lost  = HAS_TX && !link.pll_locked &&
                      (state != trs_pkg::TRS_PLL_RST) && (state != trs_pkg::TRS_PLL_WAIT);
   assign wait_done = reached(cnt, trs_pkg::PLL_RESET_CYC);

   // Next-state decode; the counter restarts on every state change.
   always_comb begin
      next_state = state;
      case (state)
         trs_pkg::TRS_PLL_RST:   if (!HAS_TX) next_state = trs_pkg::TRS_BUSY_WAIT;
                                 else if (wait_done) next_state = trs_pkg::TRS_PLL_WAIT;
         trs_pkg::TRS_PLL_WAIT:  if (link.pll_locked) next_state = trs_pkg::TRS_BUSY_WAIT;
         trs_pkg::TRS_BUSY_WAIT: if (!link.busy && (busy_seen || HAS_TX))
                                    next_state = trs_pkg::TRS_GAP;
         trs_pkg::TRS_GAP:       if (link.busy) next_state = trs_pkg::TRS_BUSY_WAIT;
                                 else if (reached(cnt, trs_pkg::BUSY_GAP_CYC - 1))
                                    next_state = MANUAL ? trs_pkg::TRS_REF_WAIT
                                                        : trs_pkg::TRS_FREQ_WAIT;
         trs_pkg::TRS_FREQ_WAIT: if (link.rx_freq_locked) next_state = trs_pkg::TRS_AUTO_WAIT;
         trs_pkg::TRS_AUTO_WAIT: if (!link.rx_freq_locked) next_state = trs_pkg::TRS_FREQ_WAIT;
                                 else if (reached(cnt, AUTO_LOCK_CYC))
                                    next_state = trs_pkg::TRS_READY;
         trs_pkg::TRS_REF_WAIT:  if (link.rx_pll_locked && reached(cnt, REF_TO_DATA_CYC))
                                    next_state = trs_pkg::TRS_DATA_WAIT;
         trs_pkg::TRS_DATA_WAIT: if (reached(cnt, MANUAL_LOCK_CYC))
                                    next_state = trs_pkg::TRS_READY;
         trs_pkg::TRS_READY:     next_state = trs_pkg::TRS_READY;
         default:                next_state = trs_pkg::TRS_PLL_RST;
      endcase
      if (pll_lost) begin
         next_state = trs_pkg::TRS_PLL_WAIT;
      end
   end
   assign cnt_clr = (next_state != state);

   // State, counter and busy memory. Busy is remembered once the calibration pulse ran,
   // since a receiver-only channel must not start before it.
   // Nothing here is shared between channels, so each instance runs on its own.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state     <= trs_pkg::TRS_PLL_RST;
         cnt       <= '0;
         busy_seen <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= (cnt_clr || &cnt) ? (cnt_clr ? '0 : cnt) : cnt + 1'b1;
         busy_seen <= busy_seen | link.busy;
      end
   end

   // ***************************************************************
   // Reset and lock outputs, all registered
   // ***************************************************************
   // Outputs follow next_state so each release lands on the transition edge.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         link.pll_reset        <= 1'b1;
         link.tx_digital_reset <= 1'b1;
         link.rx_analog_reset  <= 1'b1;
         link.rx_digital_reset <= 1'b1;
         link.lock_to_ref      <= 1'b1;
         link.lock_to_data     <= 1'b0;
         TX_READY              <= 1'b0;
         RX_READY              <= 1'b0;
      end else begin
         link.pll_reset        <= HAS_TX && (next_state == trs_pkg::TRS_PLL_RST);
         // An absent transmitter stays in reset, so only a PLL lock ever frees it.
         link.tx_digital_reset <= !HAS_TX ||
                                  (next_state == trs_pkg::TRS_PLL_RST) ||
                                  (next_state == trs_pkg::TRS_PLL_WAIT);
         link.rx_analog_reset  <= (next_state == trs_pkg::TRS_PLL_RST)  ||
                                  (next_state == trs_pkg::TRS_PLL_WAIT) ||
                                  (next_state == trs_pkg::TRS_BUSY_WAIT)||
                                  (next_state == trs_pkg::TRS_GAP);
         link.rx_digital_reset <= (next_state != trs_pkg::TRS_READY);
         link.lock_to_data     <= MANUAL && ((next_state == trs_pkg::TRS_DATA_WAIT) ||
                                  (next_state == trs_pkg::TRS_READY));
         link.lock_to_ref      <= !(MANUAL && ((next_state == trs_pkg::TRS_DATA_WAIT) ||
                                  (next_state == trs_pkg::TRS_READY)));
         TX_READY              <= HAS_TX && (next_state != trs_pkg::TRS_PLL_RST) &&
                                  (next_state != trs_pkg::TRS_PLL_WAIT);
         RX_READY              <= (next_state == trs_pkg::TRS_READY);
      end
   end
endmodule : trs_ctrl

// [tb/trs_link_monitor.sv]
// Assertions on the link between the reset sequencer and the transceiver end.
// Assumes one clock domain; instantiated by the bench beside the link interface.
`timescale 1ns/1ps
module trs_link_monitor #(
   parameter int unsigned AUTO_LOCK_CYC   = trs_pkg::AUTO_LOCK_CYC,   // Auto data-lock wait.
   parameter int unsigned REF_TO_DATA_CYC = trs_pkg::REF_TO_DATA_CYC, // Reference-to-data wait.
   parameter int unsigned MANUAL_LOCK_CYC = trs_pkg::MANUAL_LOCK_CYC  // Manual data-lock wait.
) (
   input wire logic CORE_CLK,         // Parallel clock.
   input wire logic RST_N,            // Asynchronous reset, active low.
   input wire logic HAS_TX,           // Transmitter present.
   input wire logic MANUAL,           // Manual lock mode.
   input wire logic pll_reset,        // Transmit PLL reset.
   input wire logic tx_digital_reset, // Transmit digital reset.
   input wire logic rx_analog_reset,  // Receive analog reset.
   input wire logic rx_digital_reset, // Receive digital reset.
   input wire logic lock_to_ref,      // Lock-to-reference control.
   input wire logic lock_to_data,     // Lock-to-data control.
   input wire logic pll_locked,       // Transmit PLL locked.
   input wire logic rx_freq_locked,   // CDR frequency locked.
   input wire logic rx_pll_locked,    // CDR PLL locked.
   input wire logic busy              // Reconfiguration busy.
);
   // ****************************************************************
   // Hold counters and properties
   // ****************************************************************
   logic [15:0] frq_cnt, pll_cnt, ltd_cnt, prst_cnt;
   // Each counter saturates, so a long idle run can never wrap it back under a limit.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         frq_cnt  <= 16'h0000;
         pll_cnt  <= 16'h0000;
         ltd_cnt  <= 16'h0000;
         prst_cnt <= 16'h0000;
      end else begin
         frq_cnt  <= rx_freq_locked ? frq_cnt + {15'h0000, ~&frq_cnt} : 16'h0000;
         pll_cnt  <= rx_pll_locked ? pll_cnt + {15'h0000, ~&pll_cnt} : 16'h0000;
         ltd_cnt  <= lock_to_data ? ltd_cnt + {15'h0000, ~&ltd_cnt} : 16'h0000;
         prst_cnt <= pll_reset ? prst_cnt + {15'h0000, ~&prst_cnt} : 16'h0000;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_ref_lost;
      $fell(pll_locked) ##0 HAS_TX;
   endsequence
   sequence s_cdr_released;
      $fell(rx_analog_reset) ##0 MANUAL;
   endsequence
   AST_PLL_HOLDS_ALL: assert property (pll_reset |-> tx_digital_reset &&
      rx_analog_reset && rx_digital_reset)
      else $error("Reset released under PLL reset.");
   AST_PLL_MIN: assert property ($fell(pll_reset) && HAS_TX |->
      prst_cnt >= trs_pkg::PLL_RESET_CYC)
      else $error("PLL reset too short.");
   AST_TX_AFTER_LOCK: assert property ($fell(tx_digital_reset) |-> $past(pll_locked))
      else $error("Transmit reset released unlocked.");
   AST_NO_TX_HELD: assert property (!HAS_TX |-> tx_digital_reset)
      else $error("Absent transmitter left out of reset.");
   AST_ANALOG_GAP: assert property ($fell(rx_analog_reset) |->
      !$past(busy, 1) && !$past(busy, 2))
      else $error("Analog reset released near busy.");
   AST_AUTO_WAIT: assert property ($fell(rx_digital_reset) && !MANUAL |->
      frq_cnt >= AUTO_LOCK_CYC)
      else $error("Auto data-lock wait short.");
   AST_SWAP: assert property ($fell(lock_to_ref) |-> $rose(lock_to_data) &&
      rx_pll_locked && pll_cnt >= REF_TO_DATA_CYC)
      else $error("Lock swap wrong.");
   AST_NEVER_BOTH: assert property (!(lock_to_ref && lock_to_data))
      else $error("Both lock controls high.");
   AST_MANUAL_WAIT: assert property ($fell(rx_digital_reset) && MANUAL |->
      lock_to_data && ltd_cnt >= MANUAL_LOCK_CYC)
      else $error("Manual data-lock wait short.");
   AST_CDR_LOCKS: assert property (s_cdr_released |-> ##[1:40] rx_pll_locked)
      else $error("CDR PLL lock missing.");
   AST_RELOCK: assert property (s_ref_lost |-> ##[1:3] tx_digital_reset)
      else $error("Transmit reset not reasserted.");
endmodule : trs_link_monitor

// [tb/trs_ctrl_tb.sv]
// Self-checking bench: sequencer and transceiver end joined by the link interface.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
module trs_ctrl_tb;
   // ****************************************************************
   // Bench
   // ****************************************************************
   localparam int unsigned AUTO_W = 4;
   localparam int unsigned REF_W  = 5;
   localparam int unsigned MAN_W  = 6;
   localparam int          LIMIT  = 5000; // Four configurations take well under this.
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic has_tx = 1'b0, manual = 1'b0, refclk_ok = 1'b1, reconfig_req = 1'b0;
   logic tx_ready, rx_ready, cdr_in_data;
   int   mismatches = 0, tests_run = 0, cyc = 0, seed = 92, n, b;
   trs_link_if link ();
   trs_ctrl #(.AUTO_LOCK_CYC(AUTO_W), .REF_TO_DATA_CYC(REF_W), .MANUAL_LOCK_CYC(MAN_W))
   u_trs_ctrl (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .link(link), .HAS_TX(has_tx), .MANUAL(manual),
      .TX_READY(tx_ready), .RX_READY(rx_ready));
   trs_xcvr u_trs_xcvr (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .link(link), .REFCLK_OK(refclk_ok),
      .RECONFIG_REQ(reconfig_req), .CDR_IN_DATA(cdr_in_data));
   trs_link_monitor #(.AUTO_LOCK_CYC(AUTO_W), .REF_TO_DATA_CYC(REF_W), .MANUAL_LOCK_CYC(MAN_W))
   u_trs_link_monitor (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HAS_TX(has_tx), .MANUAL(manual),
      .pll_reset(link.pll_reset), .tx_digital_reset(link.tx_digital_reset),
      .rx_analog_reset(link.rx_analog_reset), .rx_digital_reset(link.rx_digital_reset),
      .lock_to_ref(link.lock_to_ref), .lock_to_data(link.lock_to_data),
      .pll_locked(link.pll_locked), .rx_freq_locked(link.rx_freq_locked),
      .rx_pll_locked(link.rx_pll_locked), .busy(link.busy));
   // Clock and hang guard.
   always #4 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("TB: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_min(input int got, input int least);
      tests_run++;
      if (got < least) begin
         mismatches++;
         $display("Error at %0t: got %h least %h", $time, got, least);
      end
   endtask : chk_min
   // Shortest legal time from reset release to both sides ready.
   function automatic int least_ready(input logic h, input logic m);
      return (h ? int'(trs_pkg::PLL_RESET_CYC) : 0) + int'(trs_pkg::BUSY_GAP_CYC)
             + (m ? int'(REF_W + MAN_W) : int'(AUTO_W));
   endfunction : least_ready
   // Bounded wait; a miss shows up in the ready checks that follow.
   task automatic wait_ready(output int cnt);
      cnt = 0;
      while (!(rx_ready === 1'b1 && (tx_ready === 1'b1 || !has_tx)) && cnt < 2000) begin
         @(negedge CORE_CLK);
         cnt++;
      end
   endtask : wait_ready
   task automatic run_cfg(input logic h, input logic m);
      @(negedge CORE_CLK);
      RST_N = 1'b0;
      has_tx = h;
      manual = m;
      refclk_ok = 1'b1;
      repeat (6) @(negedge CORE_CLK);
      RST_N = 1'b1;
      repeat (8) @(negedge CORE_CLK);
      chk_bit(link.rx_analog_reset, 1'b1);
      chk_bit(link.rx_digital_reset, 1'b1);
      chk_bit(link.lock_to_data, 1'b0);
      chk_bit(link.pll_reset, h);
      wait_ready(n);
      chk_min(n + 8, least_ready(h, m));
      chk_bit(rx_ready, 1'b1);
      chk_bit(tx_ready, h);
      chk_bit(link.busy, 1'b0);
      if (m) begin
         chk_bit(cdr_in_data, 1'b1);
         chk_bit(link.lock_to_ref, 1'b0);
      end else begin
         chk_bit(cdr_in_data, 1'b0);
         chk_bit(link.lock_to_ref, 1'b1);
      end
      repeat ($unsigned($random(seed)) % 5) @(negedge CORE_CLK);
      reconfig_req = 1'b1;
      @(negedge CORE_CLK);
      reconfig_req = 1'b0;
      b = 0;
      repeat (5) begin
         if (link.busy === 1'b1) b++;
         @(negedge CORE_CLK);
      end
      chk_bit(b == 1, 1'b1);
      if (h) begin
         refclk_ok = 1'b0;
         for (int i = 0; i < 10 && link.pll_locked !== 1'b0; i++) @(negedge CORE_CLK);
         chk_bit(link.pll_locked, 1'b0);
         repeat (3) @(negedge CORE_CLK);
         chk_bit(link.tx_digital_reset, 1'b1);
         chk_bit(tx_ready, 1'b0);
         repeat (1 + $unsigned($random(seed)) % 20) @(negedge CORE_CLK);
         refclk_ok = 1'b1;
         wait_ready(n);
         chk_bit(tx_ready, 1'b1);
         chk_bit(rx_ready, 1'b1);
      end
   endtask : run_cfg
   initial begin
      for (int i = 0; i < 4; i++) run_cfg(i[0], i[1]);
      tally_and_finish();
   end
endmodule : trs_ctrl_tb
